/* design/acr_regs.sv */
// Summary of operation
// - Gain is 24 bits: bits 23:8 in the high word, 7:0 in low word 15:8.
// - Gain is unsigned, from zero to just under two in steps of 2/2^24.
// - Gain high words reset to 8000h and gain low words to zero.
// - Offset is 24-bit two's complement, split like the gain.
// - Both offset words of a channel reset to zero.
// - The low byte of every low word is read-only and reads zero.
// - Config bits 15:6 hold a signed phase delay in modulator cycles.
// - Config bits 5:3 are read-only and read zero.
// - Config bit 2 set turns the channel DC filter off, clear follows global.
// - Input select: pins, shorted, positive test, negative test.
`timescale 1ns/1ns
`include "acr_cfg.svh"

module acr_regs (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    input  wire logic [`ACR_DCSET_W-1:0] global_dc_filter_setting,
    input  wire logic                    chan1_raw_valid,
    input  wire logic [`ACR_CAL_W-1:0]   chan1_raw_data,
    input  wire logic [`ACR_CAL_W-1:0]   chan1_offset_value,
    input  wire logic                    chan2_raw_valid,
    input  wire logic [`ACR_CAL_W-1:0]   chan2_raw_data,
    output logic [`ACR_CAL_W-1:0]        chan1_gain,
    output logic [`ACR_CAL_W-1:0]        chan2_offset,
    output logic [`ACR_CAL_W-1:0]        chan2_gain,
    output logic [`ACR_PHASE_W-1:0]      chan2_delay_cycles,
    output logic                         chan2_dc_filter_off,
    output logic [`ACR_DCSET_W-1:0]      chan2_dc_filter_setting,
    output logic [1:0]                   chan2_input_select,
    output logic                         chan2_positive_input,
    output logic                         chan2_inputs_shorted,
    output logic                         chan2_test_pos,
    output logic                         chan2_test_neg,
    output logic                         chan1_result_valid,
    output logic [`ACR_CAL_W-1:0]        chan1_result,
    output logic                         chan2_result_valid,
    output logic [`ACR_CAL_W-1:0]        chan2_result
);

    acr_pkg::acr_state_t st_reg;
    acr_pkg::acr_state_t st_next;
    logic                accept;
    logic                addr_hit;
    logic                wr_now;

    // The slices below must match the declared widths, otherwise the
    // halves of a calibration value would land on the wrong bits.
    if (`ACR_UPPER_W + `ACR_LOWER_W != `ACR_CAL_W) begin : g_bad_split
        $error("calibration halves do not make one value");
    end
    if (`ACR_IDX_MSB - `ACR_IDX_LSB + 1 != `ACR_IDX_W) begin : g_bad_idx
        $error("register index slice has the wrong width");
    end
    if (`ACR_LOWER_MSB - `ACR_LOWER_LSB + 1 != `ACR_LOWER_W) begin : g_bad_lo
        $error("lower byte slice has the wrong width");
    end
    if (`ACR_UPPER_MSB - `ACR_UPPER_LSB + 1 != `ACR_UPPER_W) begin : g_bad_up
        $error("upper word slice has the wrong width");
    end
    if (`ACR_PHASE_MSB - `ACR_PHASE_LSB + 1 != `ACR_PHASE_W) begin : g_bad_ph
        $error("phase delay slice has the wrong width");
    end

    // Reserved fields are not stored, so they cannot read back nonzero.
    function automatic logic [`ACR_REG_W-1:0] rd_word(
        input acr_pkg::acr_state_t s
    );
        logic [`ACR_REG_W-1:0] r;
        r = `ACR_ZERO_UPPER_RST;
        case (s.idx)
            `ACR_IDX_CH1_GAIN_HI: begin
                r = s.chan1_gain_upper_bits;
            end
            `ACR_IDX_CH1_GAIN_LO: begin
                r = {s.chan1_gain_lower_bits, `ACR_RSVD_BYTE};
            end
            `ACR_IDX_CH2_CONFIG: begin
                r = {s.chan2_delay_cycles, `ACR_RSVD_CFG,
                     s.chan2_dc_filter_off, s.chan2_input_select};
            end
            `ACR_IDX_CH2_OFS_HI: begin
                r = s.chan2_offset_upper_bits;
            end
            `ACR_IDX_CH2_OFS_LO: begin
                r = {s.chan2_offset_lower_bits, `ACR_RSVD_BYTE};
            end
            `ACR_IDX_CH2_GAIN_HI: begin
                r = s.chan2_gain_upper_bits;
            end
            `ACR_IDX_CH2_GAIN_LO: begin
                r = {s.chan2_gain_lower_bits, `ACR_RSVD_BYTE};
            end
            default: begin
                r = `ACR_ZERO_UPPER_RST;
            end
        endcase
        if (!s.hit) begin
            r = `ACR_ZERO_UPPER_RST;
        end
        return r;
    endfunction

    assign accept   = hsel && htrans[`ACR_HTRANS_ACTIVE_BIT] && hready;
    // Addresses above the map would otherwise alias onto it.
    assign addr_hit = (haddr[`ACR_ADDR_HI:`ACR_IDX_MSB+1] == '0)
                   && (hsize == `ACR_HSIZE_WORD);
    assign wr_now   = (st_reg.bus == acr_pkg::ACR_BUS_WRITE) && st_reg.hit;

    always_comb begin
        st_next = st_reg;
        if (wr_now) begin
            case (st_reg.idx)
                `ACR_IDX_CH1_GAIN_HI: begin
                    st_next.chan1_gain_upper_bits =
                        hwdata[`ACR_UPPER_MSB:`ACR_UPPER_LSB];
                end
                `ACR_IDX_CH1_GAIN_LO: begin
                    st_next.chan1_gain_lower_bits =
                        hwdata[`ACR_LOWER_MSB:`ACR_LOWER_LSB];
                end
                `ACR_IDX_CH2_CONFIG: begin
                    st_next.chan2_delay_cycles =
                        hwdata[`ACR_PHASE_MSB:`ACR_PHASE_LSB];
                    st_next.chan2_dc_filter_off = hwdata[`ACR_DCOFF_BIT];
                    st_next.chan2_input_select = acr_pkg::acr_mux_t'(
                        hwdata[`ACR_MUX_MSB:`ACR_MUX_LSB]);
                end
                `ACR_IDX_CH2_OFS_HI: begin
                    st_next.chan2_offset_upper_bits =
                        hwdata[`ACR_UPPER_MSB:`ACR_UPPER_LSB];
                end
                `ACR_IDX_CH2_OFS_LO: begin
                    st_next.chan2_offset_lower_bits =
                        hwdata[`ACR_LOWER_MSB:`ACR_LOWER_LSB];
                end
                `ACR_IDX_CH2_GAIN_HI: begin
                    st_next.chan2_gain_upper_bits =
                        hwdata[`ACR_UPPER_MSB:`ACR_UPPER_LSB];
                end
                `ACR_IDX_CH2_GAIN_LO: begin
                    st_next.chan2_gain_lower_bits =
                        hwdata[`ACR_LOWER_MSB:`ACR_LOWER_LSB];
                end
                default: begin
                end
            endcase
        end
        case (st_reg.bus)
            acr_pkg::ACR_BUS_RWAIT: begin
                // One wait state lets read data leave a flip-flop.
                st_next.bus   = acr_pkg::ACR_BUS_RDONE;
                st_next.rdata = rd_word(st_reg);
            end
            acr_pkg::ACR_BUS_IDLE,
            acr_pkg::ACR_BUS_WRITE,
            acr_pkg::ACR_BUS_RDONE: begin
                if (accept) begin
                    st_next.idx = haddr[`ACR_IDX_MSB:`ACR_IDX_LSB];
                    st_next.hit = addr_hit;
                    st_next.bus = hwrite ? acr_pkg::ACR_BUS_WRITE
                                         : acr_pkg::ACR_BUS_RWAIT;
                end else begin
                    st_next.bus = acr_pkg::ACR_BUS_IDLE;
                end
            end
            default: begin
                st_next.bus = acr_pkg::ACR_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
            st_reg.chan1_gain_upper_bits   <= `ACR_GAIN_UPPER_RST;
            st_reg.chan1_gain_lower_bits   <= `ACR_LOWER_RST;
            st_reg.chan2_gain_upper_bits   <= `ACR_GAIN_UPPER_RST;
            st_reg.chan2_gain_lower_bits   <= `ACR_LOWER_RST;
            st_reg.chan2_offset_upper_bits <= `ACR_ZERO_UPPER_RST;
            st_reg.chan2_offset_lower_bits <= `ACR_LOWER_RST;
            st_reg.chan2_delay_cycles      <= `ACR_PHASE_RST;
            st_reg.chan2_dc_filter_off     <= `ACR_DCOFF_RST;
            st_reg.chan2_input_select      <= acr_pkg::ACR_MUX_PINS;
            st_reg.bus                     <= acr_pkg::ACR_BUS_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hreadyout = (st_reg.bus != acr_pkg::ACR_BUS_RWAIT);
    assign hresp     = `ACR_HRESP_OKAY;
    assign hrdata    = {`ACR_HRDATA_PAD, st_reg.rdata};

    assign chan1_gain   = {st_reg.chan1_gain_upper_bits,
                           st_reg.chan1_gain_lower_bits};
    assign chan2_gain   = {st_reg.chan2_gain_upper_bits,
                           st_reg.chan2_gain_lower_bits};
    assign chan2_offset = {st_reg.chan2_offset_upper_bits,
                           st_reg.chan2_offset_lower_bits};

    assign chan2_delay_cycles  = st_reg.chan2_delay_cycles;
    assign chan2_dc_filter_off = st_reg.chan2_dc_filter_off;
    assign chan2_dc_filter_setting = st_reg.chan2_dc_filter_off
                                   ? `ACR_DC_FILTER_NONE
                                   : global_dc_filter_setting;

    assign chan2_input_select   = st_reg.chan2_input_select;
    assign chan2_positive_input =
        (st_reg.chan2_input_select == acr_pkg::ACR_MUX_PINS);
    assign chan2_inputs_shorted =
        (st_reg.chan2_input_select == acr_pkg::ACR_MUX_SHORT);
    assign chan2_test_pos =
        (st_reg.chan2_input_select == acr_pkg::ACR_MUX_TEST_POS);
    assign chan2_test_neg =
        (st_reg.chan2_input_select == acr_pkg::ACR_MUX_TEST_NEG);

    // Channel 1 offset lives in another bank and arrives as an input.
    acr_corr #(
        .DATA_W (`ACR_CAL_W)
    ) u_corr_ch1 (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (chan1_raw_valid),
        .in_data   (chan1_raw_data),
        .offset    (chan1_offset_value),
        .gain      (chan1_gain),
        .out_valid (chan1_result_valid),
        .out_data  (chan1_result)
    );

    acr_corr #(
        .DATA_W (`ACR_CAL_W)
    ) u_corr_ch2 (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (chan2_raw_valid),
        .in_data   (chan2_raw_data),
        .offset    (chan2_offset),
        .gain      (chan2_gain),
        .out_valid (chan2_result_valid),
        .out_data  (chan2_result)
    );

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    gain_reset_a: assert property (
        $rose(hresetn) |-> chan1_gain == {`ACR_GAIN_UPPER_RST,
        `ACR_LOWER_RST} && chan2_gain == {`ACR_GAIN_UPPER_RST,
        `ACR_LOWER_RST})
        else $error("gain not at reset value");
    offset_reset_a: assert property (
        $rose(hresetn) |-> chan2_offset == '0)
        else $error("offset not zero after reset");
    gain_upper_a: assert property (
        wr_now && st_reg.idx == `ACR_IDX_CH1_GAIN_HI
        |=> chan1_gain[23:8] == $past(hwdata[15:0]))
        else $error("gain upper word not stored");
    gain_lower_a: assert property (
        wr_now && st_reg.idx == `ACR_IDX_CH2_GAIN_LO
        |=> chan2_gain[7:0] == $past(hwdata[15:8])
        && $stable(chan2_gain[23:8]))
        else $error("gain lower byte not stored");
    offset_lower_a: assert property (
        wr_now && st_reg.idx == `ACR_IDX_CH2_OFS_LO
        |=> chan2_offset[7:0] == $past(hwdata[15:8]))
        else $error("offset lower byte not stored");
    low_rsvd_a: assert property (
        st_reg.bus == acr_pkg::ACR_BUS_RWAIT
        && st_reg.idx inside {`ACR_IDX_CH1_GAIN_LO, `ACR_IDX_CH2_OFS_LO,
        `ACR_IDX_CH2_GAIN_LO}
        |=> hreadyout && hrdata[7:0] == '0)
        else $error("reserved low byte read nonzero");
    cfg_rsvd_a: assert property (
        st_reg.bus == acr_pkg::ACR_BUS_RWAIT
        && st_reg.idx == `ACR_IDX_CH2_CONFIG |=> hrdata[5:3] == '0)
        else $error("reserved config bits read nonzero");
    phase_store_a: assert property (
        wr_now && st_reg.idx == `ACR_IDX_CH2_CONFIG
        |=> chan2_delay_cycles == $past(hwdata[15:6]))
        else $error("phase delay not stored");
    dc_off_a: assert property (
        wr_now && st_reg.idx == `ACR_IDX_CH2_CONFIG && hwdata[2]
        |=> chan2_dc_filter_setting == '0)
        else $error("filter not disabled for channel");
    mux_short_a: assert property (
        wr_now && st_reg.idx == `ACR_IDX_CH2_CONFIG && hwdata[1:0] == 2'h1
        |=> chan2_inputs_shorted && !chan2_positive_input)
        else $error("short selection not decoded");
    offset_upper_a: assert property (
        wr_now && st_reg.idx == `ACR_IDX_CH2_OFS_HI
        |=> chan2_offset[23:8] == $past(hwdata[15:0]))
        else $error("offset upper word not stored");
    gain1_lower_a: assert property (
        wr_now && st_reg.idx == `ACR_IDX_CH1_GAIN_LO
        |=> chan1_gain[7:0] == $past(hwdata[15:8]))
        else $error("channel 1 gain lower byte not stored");
    cfg_reset_a: assert property (
        $rose(hresetn) |-> chan2_positive_input && !chan2_dc_filter_off
        && chan2_delay_cycles == '0)
        else $error("channel config not at reset value");
    dc_follow_a: assert property (
        !chan2_dc_filter_off
        |-> chan2_dc_filter_setting == global_dc_filter_setting)
        else $error("channel filter does not follow global setting");
    mux_neg_a: assert property (
        wr_now && st_reg.idx == `ACR_IDX_CH2_CONFIG
        && hwdata[`ACR_MUX_MSB:`ACR_MUX_LSB] == acr_pkg::ACR_MUX_TEST_NEG
        |=> chan2_test_neg && !chan2_test_pos && !chan2_positive_input)
        else $error("negative test selection not decoded");
    miss_read_a: assert property (
        st_reg.bus == acr_pkg::ACR_BUS_RWAIT && !st_reg.hit |=> hrdata == '0)
        else $error("refused read returned data");
    // A refused write must leave every calibration value untouched.
    write_miss_a: assert property (
        st_reg.bus == acr_pkg::ACR_BUS_WRITE && (!st_reg.hit
        || !(st_reg.idx inside {[`ACR_IDX_CH1_GAIN_HI:`ACR_IDX_CH2_GAIN_LO]}))
        |=> $stable(chan1_gain) && $stable(chan2_gain)
        && $stable(chan2_offset))
        else $error("refused write changed a register");
    read_wait_a: assert property (
        accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state not exactly one cycle");

    write_c: cover property (wr_now && st_reg.idx == `ACR_IDX_CH2_CONFIG);
    read_c: cover property (st_reg.bus == acr_pkg::ACR_BUS_RDONE
        && st_reg.idx == `ACR_IDX_CH2_GAIN_HI);
    back_to_back_c: cover property (wr_now && accept && !hwrite);
    result_c: cover property (chan2_result_valid);

endmodule

/* design/acr_cfg.svh */
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// Register indices; byte address is four times the index.
`define ACR_IDX_CH1_GAIN_HI 6'h11
`define ACR_IDX_CH1_GAIN_LO 6'h12
`define ACR_IDX_CH2_CONFIG     6'h13
`define ACR_IDX_CH2_OFS_HI  6'h14
`define ACR_IDX_CH2_OFS_LO  6'h15
`define ACR_IDX_CH2_GAIN_HI 6'h16
`define ACR_IDX_CH2_GAIN_LO 6'h17

`define ACR_IDX_W   6
`define ACR_IDX_MSB 7
`define ACR_IDX_LSB 2
`define ACR_ADDR_HI 31

`define ACR_REG_W   16
`define ACR_UPPER_W 16
`define ACR_LOWER_W 8
`define ACR_PHASE_W 10
`define ACR_CAL_W   24
`define ACR_DCSET_W 4

`define ACR_UPPER_MSB  15
`define ACR_UPPER_LSB  0
`define ACR_LOWER_MSB  15
`define ACR_LOWER_LSB  8
`define ACR_PHASE_MSB  15
`define ACR_PHASE_LSB  6
`define ACR_DCOFF_BIT  2
`define ACR_MUX_MSB    1
`define ACR_MUX_LSB    0

`define ACR_GAIN_UPPER_RST 16'h8000
`define ACR_ZERO_UPPER_RST 16'h0000
`define ACR_LOWER_RST      8'h00
`define ACR_PHASE_RST      10'h000
`define ACR_DCOFF_RST      1'h0
`define ACR_RSVD_BYTE      8'h00
`define ACR_RSVD_CFG       3'h0
`define ACR_HRDATA_PAD     16'h0000
`define ACR_DC_FILTER_NONE 4'h0

`define ACR_HTRANS_ACTIVE_BIT 1
`define ACR_HSIZE_WORD        3'h2
`define ACR_HRESP_OKAY        1'h0

`endif

/* design/acr_pkg.sv */
`include "acr_cfg.svh"

package acr_pkg;

    typedef enum logic [1:0] {
        ACR_BUS_IDLE  = 2'h0,
        ACR_BUS_WRITE = 2'h1,
        ACR_BUS_RWAIT = 2'h2,
        ACR_BUS_RDONE = 2'h3
    } acr_bus_t;

    typedef enum logic [1:0] {
        ACR_MUX_PINS     = 2'h0,
        ACR_MUX_SHORT    = 2'h1,
        ACR_MUX_TEST_POS = 2'h2,
        ACR_MUX_TEST_NEG = 2'h3
    } acr_mux_t;

    typedef struct packed {
        acr_bus_t                 bus;
        logic [`ACR_IDX_W-1:0]    idx;
        logic                     hit;
        logic [`ACR_REG_W-1:0]    rdata;
        logic [`ACR_UPPER_W-1:0]  chan1_gain_upper_bits;
        logic [`ACR_LOWER_W-1:0]  chan1_gain_lower_bits;
        logic [`ACR_PHASE_W-1:0]  chan2_delay_cycles;
        logic                     chan2_dc_filter_off;
        acr_mux_t                 chan2_input_select;
        logic [`ACR_UPPER_W-1:0]  chan2_offset_upper_bits;
        logic [`ACR_LOWER_W-1:0]  chan2_offset_lower_bits;
        logic [`ACR_UPPER_W-1:0]  chan2_gain_upper_bits;
        logic [`ACR_LOWER_W-1:0]  chan2_gain_lower_bits;
    } acr_state_t;

endpackage

/* design/acr_corr.sv */
`timescale 1ns/1ns
`include "acr_cfg.svh"

module acr_corr #(
    parameter int DATA_W = `ACR_CAL_W
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              in_valid,
    input  wire logic [DATA_W-1:0] in_data,
    input  wire logic [DATA_W-1:0] offset,
    input  wire logic [DATA_W-1:0] gain,
    output logic                   out_valid,
    output logic [DATA_W-1:0]      out_data
);

    localparam int PW = 2 * DATA_W + 2;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } acr_corr_state_t;

    localparam logic signed [PW-1:0] SAT_HI =
        $signed({{(DATA_W+3){1'h0}}, {(DATA_W-1){1'h1}}});
    localparam logic signed [PW-1:0] SAT_LO =
        $signed({{(DATA_W+3){1'h1}}, {(DATA_W-1){1'h0}}});
    localparam logic [DATA_W-1:0] POS_MAX = {1'h0, {(DATA_W-1){1'h1}}};
    localparam logic [DATA_W-1:0] NEG_MAX = {1'h1, {(DATA_W-1){1'h0}}};
    localparam logic [DATA_W-1:0] UNITY   = {1'h1, {(DATA_W-1){1'h0}}};

    if (DATA_W < 2) begin : g_bad_width
        $error("acr_corr needs DATA_W of at least 2");
    end

    acr_corr_state_t        st_reg;
    acr_corr_state_t        st_next;
    logic signed [DATA_W:0] diff;
    logic signed [PW-1:0]   prod;
    logic signed [PW-1:0]   scaled;

    assign diff   = $signed({in_data[DATA_W-1], in_data})
                  - $signed({offset[DATA_W-1], offset});
    assign prod   = diff * $signed({1'h0, gain});
    assign scaled = prod >>> (DATA_W - 1);

    always_comb begin
        st_next       = st_reg;
        st_next.valid = in_valid;
        if (in_valid) begin
            if (scaled > SAT_HI) begin
                st_next.data = POS_MAX;
            end else if (scaled < SAT_LO) begin
                st_next.data = NEG_MAX;
            end else begin
                st_next.data = scaled[DATA_W-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign out_valid = st_reg.valid;
    assign out_data  = st_reg.data;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    unity_pass_a: assert property (
        in_valid && gain == UNITY && offset == '0
        |=> out_valid && out_data == $past(in_data))
        else $error("unity gain did not pass sample through");
    zero_gain_a: assert property (
        in_valid && gain == '0 |=> out_data == '0)
        else $error("zero gain did not give zero");
    sat_high_a: assert property (
        in_valid && in_data == POS_MAX && offset == NEG_MAX
        && gain >= UNITY |=> out_data == POS_MAX)
        else $error("positive overflow not saturated");
    saturate_c: cover property (in_valid && scaled > SAT_HI);

endmodule

/* tb/adc_channel_calibration_regs_tb_top.sv */
`timescale 1ns/1ns
module adc_channel_calibration_regs_tb_top;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [3:0]  gdc;
    logic        v1;
    logic        v2;
    logic [23:0] d1;
    logic [23:0] d2;
    logic [23:0] ofs1;
    logic [23:0] g1, o2, g2, r1, r2;
    logic [9:0]  dly;
    logic        dcoff, rv1, rv2, pin, shrt, tpos, tneg;
    logic [3:0]  dcset;
    logic [1:0]  sel;
    logic [31:0] rd;
    int          n_mismatch = 0;
    int          tests_run = 0;
    logic [31:0] addr_t [0:6] = '{32'h44, 32'h48, 32'h4c, 32'h50,
                                  32'h54, 32'h58, 32'h5c};
    logic [31:0] rst_t [0:6] = '{32'h8000, 32'h0, 32'h0, 32'h0,
                                 32'h0, 32'h8000, 32'h0};
    logic [31:0] ones_t [0:6] = '{32'hffff, 32'hff00, 32'hffc7, 32'hffff,
                                  32'hff00, 32'hffff, 32'hff00};
    assign hready = hreadyout;
    acr_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .global_dc_filter_setting(gdc),
        .chan1_raw_valid(v1), .chan1_raw_data(d1),
        .chan1_offset_value(ofs1), .chan2_raw_valid(v2),
        .chan2_raw_data(d2), .chan1_gain(g1), .chan2_offset(o2),
        .chan2_gain(g2), .chan2_delay_cycles(dly),
        .chan2_dc_filter_off(dcoff), .chan2_dc_filter_setting(dcset),
        .chan2_input_select(sel), .chan2_positive_input(pin),
        .chan2_inputs_shorted(shrt), .chan2_test_pos(tpos),
        .chan2_test_neg(tneg), .chan1_result_valid(rv1),
        .chan1_result(r1), .chan2_result_valid(rv2), .chan2_result(r2));
    always #50 hclk = ~hclk;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // Every bus wait is bounded so a stuck slave ends the run.
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                n_mismatch++;
                end_sim();
            end
            @(posedge hclk);
        end
    endtask
    task automatic bus_write(logic [31:0] a, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= 1'b1;
        hsize <= 3'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        #1;
    endtask
    task automatic bus_read(logic [31:0] a, output logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        wait_ready();
        htrans <= 2'h0;
        wait_ready();
        d = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask
    function automatic logic [23:0] model(logic [23:0] x, o, g);
        longint dif;
        longint p;
        dif = longint'($signed(x)) - longint'($signed(o));
        p = (dif * longint'({40'h0, g})) >>> 23;
        if (p > 64'sd8388607)
            p = 64'sd8388607;
        if (p < -64'sd8388608)
            p = -64'sd8388608;
        return p[23:0];
    endfunction
    // Result appears exactly one cycle after the sample is taken.
    task automatic sample(bit ch, logic [23:0] x, logic [23:0] exp);
        if (ch) begin
            v2 <= 1'b1;
            d2 <= x;
        end else begin
            v1 <= 1'b1;
            d1 <= x;
        end
        @(posedge hclk);
        v1 <= 1'b0;
        v2 <= 1'b0;
        #1;
        check("valid", {31'h0, ch ? rv2 : rv1}, 32'h1);
        check("result", {8'h0, ch ? r2 : r1}, {8'h0, exp});
        @(posedge hclk);
    endtask
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        gdc = 4'h5;
        v1 = 1'b0;
        v2 = 1'b0;
        d1 = 24'h0;
        d2 = 24'h0;
        ofs1 = 24'h000001;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 7; i++) begin
            bus_read(addr_t[i], rd);
            check("reset value", rd, rst_t[i]);
        end
        check("ch1 gain", {8'h0, g1}, 32'h800000);
        sample(1'b0, 24'h000100, 24'h0000ff);
        for (int i = 0; i < 7; i++)
            bus_write(addr_t[i], 32'hffffffff);
        for (int i = 0; i < 7; i++) begin
            bus_read(addr_t[i], rd);
            check("ones readback", rd, ones_t[i]);
        end
        check("ch1 gain", {8'h0, g1}, 32'hffffff);
        sample(1'b0, 24'h400000, model(24'h400000, 24'h1, 24'hffffff));
        ofs1 <= 24'h800000;
        sample(1'b0, 24'h7fffff, 24'h7fffff);
        bus_write(32'h54, 32'h1000);
        bus_write(32'h50, 32'h0);
        bus_write(32'h58, 32'hc000);
        bus_write(32'h5c, 32'h0);
        check("ch2 offset", {8'h0, o2}, 32'h000010);
        check("ch2 gain", {8'h0, g2}, 32'hc00000);
        sample(1'b1, 24'h000110, 24'h000180);
        sample(1'b1, 24'h800000, 24'h800000);
        bus_write(32'h50, 32'hffff);
        check("ch2 offset neg", {8'h0, o2}, 32'hffff10);
        sample(1'b1, 24'h000000, model(24'h0, 24'hffff10, 24'hc00000));
        for (int m = 0; m < 4; m++) begin
            bus_write(32'h4c, 32'h8040 | m | (m[0] << 2));
            check("delay", {22'h0, dly}, 32'h201);
            check("select", {30'h0, sel}, m);
            check("decode", {28'h0, pin, shrt, tpos, tneg}, 32'h8 >> m);
            check("dc off", {31'h0, dcoff}, m & 1);
            check("dc set", {28'h0, dcset}, m[0] ? 32'h0 : 32'h5);
            bus_read(32'h4c, rd);
            check("cfg readback", rd, 32'h8040 | m | (m[0] << 2));
        end
        bus_write(32'h58, 32'h0);
        sample(1'b1, 24'h7fffff, 24'h000000);
        bus_write(32'h60, 32'hffff);
        bus_read(32'h60, rd);
        check("unmapped", rd, 32'h0);
        bus_read(32'h144, rd);
        check("high address", rd, 32'h0);
        bus_write(32'h144, 32'h1234);
        check("high address write", {8'h0, g1}, 32'hffffff);
        // A reset in mid-run must bring back values that were overwritten.
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("reset ch1 gain", {8'h0, g1}, 32'h800000);
        check("reset ch2 gain", {8'h0, g2}, 32'h800000);
        check("reset ch2 offset", {8'h0, o2}, 32'h0);
        bus_read(32'h4c, rd);
        check("reset cfg", rd, 32'h0);
        sample(1'b1, 24'h123456, 24'h123456);
        end_sim();
    end
endmodule
